// ==== serial_rx_error_flags_cfg.svh ====
// constants for the receive error flag block
`ifndef SERIAL_RX_ERROR_FLAGS_CFG_SVH
`define SERIAL_RX_ERROR_FLAGS_CFG_SVH

`define SREF_CHAR_W 8
`define SREF_WORD_W 9
`define SREF_FIFO_DEPTH 8
`define SREF_FIFO_AW 3
`define SREF_FLAG_N 4
`define SREF_IDX_FULL 3
`define SREF_IDX_OVR 2
`define SREF_IDX_ERS 1
`define SREF_IDX_PAR 0
`define SREF_WORD_PAR_BIT 8
`define SREF_FLAGS_RST 4'h0
`define SREF_DATA_RST 8'h00

`endif

// ==== serial_rx_error_flags_pkg.sv ====
// types shared by the receive error flag block
`include "serial_rx_error_flags_cfg.svh"

package serial_rx_error_flags_pkg;
	typedef logic [`SREF_FLAG_N-1:0] flag_vec_t;
	typedef logic [`SREF_CHAR_W-1:0] rx_char_t;
	typedef logic [`SREF_WORD_W-1:0] rx_word_t;
endpackage

// ==== rx_char_fifo.sv ====
// flip-flop fifo between the character receiver and the flag logic
`timescale 1ns/1ps

module rx_char_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [AW:0] count_reg, count_next;
	logic ready_reg, ready_next, valid_reg, valid_next;
	logic push, pop;

	always_comb begin
		push = in_valid_i & ready_reg;
		pop = out_ready_i & valid_reg;
		wr_ptr_next = push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
		rd_ptr_next = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
		count_next = count_reg;
		if (push && !pop) begin
			count_next = (AW+1)'(count_reg + 1'b1);
		end else if (pop && !push) begin
			count_next = (AW+1)'(count_reg - 1'b1);
		end
		// full and empty held in flops so both handshake outputs are registered
		ready_next = count_next != (AW+1)'(DEPTH);
		valid_next = count_next != '0;
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			ready_reg <= 1'b0;
			valid_reg <= 1'b0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg <= count_next;
			ready_reg <= ready_next;
			valid_reg <= valid_next;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	assign in_ready_o = ready_reg;
	assign out_valid_o = valid_reg;
	assign out_data_o = mem_reg[rd_ptr_reg];
endmodule

// ==== serial_rx_error_flags.sv ====
// receive error flags of a smart card serial interface
`timescale 1ns/1ps
`include "serial_rx_error_flags_cfg.svh"

module serial_rx_error_flags
	import serial_rx_error_flags_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic rx_enable_bit_i,
	input wire logic smart_card_select_i,
	input wire logic sync_mode_i,
	input wire logic rx_valid_i,
	input wire logic [`SREF_CHAR_W-1:0] rx_char_i,
	input wire logic rx_parity_bad_i,
	output logic rx_ready_o,
	input wire logic err_sample_i,
	input wire logic err_line_i,
	input wire logic status_rd_i,
	input wire logic status_wr_i,
	input wire logic [`SREF_FLAG_N-1:0] status_wdata_i,
	output logic rx_full_flag_o,
	output logic overrun_flag_o,
	output logic error_signal_flag_o,
	output logic parity_fault_flag_o,
	output logic [`SREF_CHAR_W-1:0] rx_data_o,
	output logic tx_stop_o
);
	flag_vec_t flags_reg, flags_next;
	flag_vec_t armed_reg, armed_next;
	flag_vec_t set_vec, clr_vec;
	rx_char_t rx_data_reg, rx_data_next;
	logic tx_stop_reg, tx_stop_next;
	logic fifo_valid, fifo_pop, blocked;
	rx_word_t fifo_word;

	// a clear needs a prior read that saw the bit at 1, and a 0 in the written bit
	function automatic logic clear_hit(input logic armed, input logic wr, input logic wbit);
		clear_hit = armed & wr & ~wbit;
	endfunction

	// queued characters wait in the fifo while the overrun or parity flag blocks reception;
	// once it is full the receiver sees rx_ready_o low
	rx_char_fifo #(
		.WIDTH(`SREF_WORD_W),
		.DEPTH(`SREF_FIFO_DEPTH),
		.AW(`SREF_FIFO_AW)
	) u_fifo (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.in_valid_i(rx_valid_i),
		.in_ready_o(rx_ready_o),
		.in_data_i({rx_parity_bad_i, rx_char_i}),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_word)
	);

	always_comb begin
		blocked = flags_reg[`SREF_IDX_OVR] | flags_reg[`SREF_IDX_PAR];
		// receive-enable only pauses completion; it never touches a flag
		fifo_pop = fifo_valid & rx_enable_bit_i & ~blocked;
		set_vec = '0;
		rx_data_next = rx_data_reg;
		if (fifo_pop) begin
			if (flags_reg[`SREF_IDX_FULL]) begin
				set_vec[`SREF_IDX_OVR] = 1'b1;
			end else if (fifo_word[`SREF_WORD_PAR_BIT]) begin
				set_vec[`SREF_IDX_PAR] = 1'b1;
				rx_data_next = fifo_word[`SREF_CHAR_W-1:0];
			end else begin
				set_vec[`SREF_IDX_FULL] = 1'b1;
				rx_data_next = fifo_word[`SREF_CHAR_W-1:0];
			end
		end
		// the error-signal flag has meaning only in smart card mode
		set_vec[`SREF_IDX_ERS] = err_sample_i & ~err_line_i & smart_card_select_i;
	end

	genvar g;
	generate
		for (g = 0; g < `SREF_FLAG_N; g++) begin : g_flag
			always_comb begin
				clr_vec[g] = clear_hit(armed_reg[g], status_wr_i, status_wdata_i[g]);
				// set wins so an event in the clearing cycle is not lost
				flags_next[g] = set_vec[g] | (flags_reg[g] & ~clr_vec[g]);
				armed_next[g] = armed_reg[g];
				if (status_wr_i) begin
					armed_next[g] = 1'b0;
				end
				if (status_rd_i && flags_reg[g]) begin
					armed_next[g] = 1'b1;
				end
				if (!flags_next[g]) begin
					armed_next[g] = 1'b0;
				end
			end
		end
	endgenerate

	always_comb begin
		tx_stop_next = sync_mode_i & (flags_next[`SREF_IDX_OVR] | flags_next[`SREF_IDX_PAR]);
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			flags_reg <= `SREF_FLAGS_RST;
			armed_reg <= '0;
			rx_data_reg <= `SREF_DATA_RST;
			tx_stop_reg <= 1'b0;
		end else begin
			flags_reg <= flags_next;
			armed_reg <= armed_next;
			rx_data_reg <= rx_data_next;
			tx_stop_reg <= tx_stop_next;
		end
	end

	assign rx_full_flag_o = flags_reg[`SREF_IDX_FULL];
	assign overrun_flag_o = flags_reg[`SREF_IDX_OVR];
	assign error_signal_flag_o = flags_reg[`SREF_IDX_ERS];
	assign parity_fault_flag_o = flags_reg[`SREF_IDX_PAR];
	assign rx_data_o = rx_data_reg;
	assign tx_stop_o = tx_stop_reg;
endmodule

// ==== serial_rx_error_flags_sva.sv ====
// assertions on the receive error flag block
`timescale 1ns/1ps
module serial_rx_error_flags_sva (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic smart_card_select_i,
	input wire logic sync_mode_i,
	input wire logic err_sample_i,
	input wire logic err_line_i,
	input wire logic status_rd_i,
	input wire logic status_wr_i,
	input wire logic [3:0] status_wdata_i,
	input wire logic overrun_flag_o,
	input wire logic error_signal_flag_o,
	input wire logic parity_fault_flag_o,
	input wire logic tx_stop_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	sequence ovr_clear_s;
		status_rd_i && overrun_flag_o ##1 status_wr_i && !status_wdata_i[2];
	endsequence
	AST_RST: assert property (disable iff (1'b0) reset_i |=> !overrun_flag_o)
		else $error("overrun after reset");
	AST_ERS_SET: assert property (err_sample_i && !err_line_i && smart_card_select_i |=> error_signal_flag_o)
		else $error("error flag not set");
	AST_OVR_HOLD: assert property (overrun_flag_o && !status_wr_i |=> overrun_flag_o)
		else $error("overrun lost");
	AST_ERS_HOLD: assert property (error_signal_flag_o && !status_wr_i |=> error_signal_flag_o)
		else $error("error flag lost");
	AST_PAR_HOLD: assert property (parity_fault_flag_o && !status_wr_i |=> parity_fault_flag_o)
		else $error("parity flag lost");
	AST_WR_ONE: assert property (status_wr_i && status_wdata_i[2] && overrun_flag_o |=> overrun_flag_o)
		else $error("write of one cleared");
	AST_OVR_CLR: assert property (ovr_clear_s |=> !overrun_flag_o)
		else $error("overrun not cleared");
	AST_TX_STOP: assert property (tx_stop_o == ($past(sync_mode_i) && (overrun_flag_o || parity_fault_flag_o)))
		else $error("transmit stop wrong");
endmodule
bind serial_rx_error_flags serial_rx_error_flags_sva serial_rx_error_flags_sva_i (.*);

// ==== card_model.sv ====
// card side: hands finished characters to the block over valid and ready
`timescale 1ns/1ps
module card_model (
	input wire logic clk_sys_i,
	input wire logic rx_ready_i,
	output logic rx_valid_o = 1'b0,
	output logic [7:0] rx_char_o = 8'h00,
	output logic bad_o = 1'b0
);
	task automatic send(input logic [7:0] c, input logic b);
		@(posedge clk_sys_i);
		rx_valid_o <= 1'b1;
		rx_char_o <= c;
		bad_o <= b;
		do @(posedge clk_sys_i); while (rx_ready_i !== 1'b1);
		rx_valid_o <= 1'b0;
		// released data must not look like the old character
		rx_char_o <= ~c;
	endtask
endmodule

// ==== serial_rx_error_flags_tb.sv ====
// self-checking bench for the receive error flag block
`timescale 1ns/1ps
module serial_rx_error_flags_tb;
	import serial_rx_error_flags_pkg::*;
	logic clk_sys_i = 0, reset_i = 1, en = 1, sc = 1, es = 0, el = 1, rd = 0, wr = 0, sm = 1;
	logic vld, bad, rdy, full, ovr, error_signal_flag, par, txs;
	logic [3:0] wd = 4'h0;
	logic [31:0] lf = 32'h37DC;
	rx_char_t ch, dat, c, p;
	int error_cnt = 0, num_checks = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	serial_rx_error_flags serial_rx_error_flags_i (.clk_sys_i, .reset_i, .rx_enable_bit_i(en),
		.smart_card_select_i(sc), .sync_mode_i(sm), .rx_valid_i(vld), .rx_char_i(ch),
		.rx_parity_bad_i(bad), .rx_ready_o(rdy), .err_sample_i(es), .err_line_i(el),
		.status_rd_i(rd), .status_wr_i(wr), .status_wdata_i(wd), .rx_full_flag_o(full),
		.overrun_flag_o(ovr), .error_signal_flag_o(error_signal_flag), .parity_fault_flag_o(par),
		.rx_data_o(dat), .tx_stop_o(txs));
	card_model card_model_i (.clk_sys_i, .rx_ready_i(rdy), .rx_valid_o(vld), .rx_char_o(ch),
		.bad_o(bad));
	function automatic rx_char_t rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf[7:0];
	endfunction
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic clr(logic [3:0] w, logic r);
		@(posedge clk_sys_i) rd <= r;
		@(posedge clk_sys_i) rd <= 1'b0;
		wr <= 1'b1;
		wd <= w;
		@(posedge clk_sys_i) wr <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
	endtask
	task automatic pulse();
		@(posedge clk_sys_i) es <= 1'b1;
		el <= 1'b0;
		@(posedge clk_sys_i) es <= 1'b0;
		el <= 1'b1;
		@(posedge clk_sys_i);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_sys_i);
		chk("flags", 8'h00, {full, ovr, error_signal_flag, par});
		reset_i <= 1'b0;
		c = rnd();
		p = rnd();
		card_model_i.send(c, 1'b0);
		repeat (3) @(posedge clk_sys_i);
		chk("full", 8'h01, full);
		card_model_i.send(~c, 1'b0);
		repeat (3) @(posedge clk_sys_i);
		chk("ovr", 8'h01, ovr);
		chk("data", c, dat);
		chk("txstop", 8'h01, txs);
		en <= 1'b0;
		clr(4'h4, 1'b1);
		chk("wr1", 8'h01, ovr);
		clr(4'h0, 1'b0);
		chk("noread", 8'h01, ovr);
		card_model_i.send(p, 1'b1);
		clr(4'h0, 1'b1);
		chk("ovrclr", 8'h00, ovr);
		en <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		chk("pdata", p, dat);
		chk("pflags", 8'h03, {full, par, txs});
		repeat (8) card_model_i.send(rnd(), 1'b0);
		en <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		chk("refuse", 8'h01, {rdy, par});
		chk("held", p, dat);
		sm <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		chk("txoff", 8'h00, txs);
		sm <= 1'b1;
		en <= 1'b1;
		repeat (12) clr(4'h0, 1'b1);
		chk("drained", 8'h04, {rdy, ovr, par});
		sc <= 1'b0;
		pulse();
		chk("ers_off", 8'h00, error_signal_flag);
		sc <= 1'b1;
		pulse();
		chk("ers", 8'h01, error_signal_flag);
		clr(4'h0, 1'b1);
		chk("ersclr", 8'h00, error_signal_flag);
		complete_run;
	end
	initial begin
		#20000;
		error_cnt++;
		complete_run;
	end
endmodule
